/* File: hdl/ltje_cfg.svh */
/*
  Constants for the literal transfer and jump execution block: opcodes,
  instruction field positions, special destination codes and reset values.
  Assumes the including file is compiled after nothing that defines these.
*/
`ifndef LTJE_CFG_SVH
`define LTJE_CFG_SVH

// ****************************************************************
// Opcodes and field positions (bit 15 of the word is its MSB).
// ****************************************************************
`define LTJE_OP_LITERAL   3'h6
`define LTJE_OP_JUMP      3'h7
`define LTJE_OP_MSB       15
`define LTJE_OP_LSB       13
`define LTJE_DST_MSB      12
`define LTJE_DST_LSB      8
`define LTJE_POS_MSB      7
`define LTJE_POS_LSB      5
`define LTJE_LEN_MSB      7
`define LTJE_LEN_LSB      5
`define LTJE_BFPOS_MSB    10
`define LTJE_BFPOS_LSB    8
`define LTJE_BANK_MSB     12
`define LTJE_BANK_LSB     11

// ****************************************************************
// Destination codes (octal values written in hex).
// ****************************************************************
`define LTJE_D_LEFT_ADDR  5'h07
`define LTJE_D_RIGHT_ADDR 5'h0F
`define LTJE_D_LEFT_DATA  5'h0A
`define LTJE_D_RIGHT_DATA 5'h0B
`define LTJE_BANK_LEFT    2'h2
`define LTJE_BANK_RIGHT   2'h3

// ****************************************************************
// Register map and reset values.
// ****************************************************************
`define LTJE_ADDR_CTRL    8'h00
`define LTJE_ADDR_INSTR   8'h04
`define LTJE_ADDR_STATUS  8'h08
`define LTJE_ADDR_LPORT   8'h0C
`define LTJE_ADDR_RPORT   8'h10
`define LTJE_ADDR_REGRD   8'h14
`define LTJE_RST_PC       13'h0000
`define LTJE_RST_BYTE     8'h00

`endif

/* File: hdl/ltje_pkg.sv */
/*
  Types shared by the literal transfer and jump execution block.
  Assumes ltje_cfg.svh supplies the numeric constants.
*/
package ltje_pkg;

  typedef struct packed {
    logic       valid;
    logic       bank_right;
    logic [7:0] data;
  } ltje_port_wr_t;

  typedef struct packed {
    logic       valid;
    logic       bank_right;
    logic [7:0] addr;
  } ltje_port_sel_t;

  typedef enum logic [2:0] {
    LTJE_IDLE  = 3'b001,
    LTJE_EXEC  = 3'b010,
    LTJE_MERGE = 3'b100
  } ltje_state_t;

endpackage : ltje_pkg

/* File: hdl/ltje_regfile.sv */
/*
  Working register file of sixteen bytes with a registered read port.
  Assumes a single clock and one write per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module ltje_regfile (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       we,
  input  wire logic [3:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [3:0] raddr,
  output var  logic [7:0] rdata_q
);
  logic [7:0] mem_q [16];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 16; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem_q[raddr];
    end
  end
endmodule : ltje_regfile
`default_nettype wire

/* File: hdl/ltje_merge.sv */
/*
  Combinational bit field shifter and merger for the bit-field port write.
  Assumes the caller presents latched port data and instruction fields.
*/
`timescale 1ns/1ps
`default_nettype none
module ltje_merge (
  input  wire logic [7:0] latched,
  input  wire logic [4:0] literal,
  input  wire logic [2:0] pos,
  input  wire logic [2:0] len,
  output var  logic [7:0] merged
);
  logic [3:0]  width;
  logic [15:0] mask16;
  logic [15:0] field16;
  logic [7:0]  mask;

  always_comb begin
    width   = (len == 3'h0) ? 4'h8 : {1'b0, len};
    // Only five literal bits exist; longer fields get zeros above them.
    field16 = {11'h000, literal} << pos;
    mask16  = (16'h00FF >> (4'h8 - width)) << pos;
    // Bits shifted past the port edge are dropped, as on a byte port.
    mask    = mask16[7:0];
    merged  = (latched & ~mask) | (field16[7:0] & mask);
  end
endmodule : ltje_merge
`default_nettype wire

/* File: hdl/ltje_exec.sv */
/*
  Execution unit for the literal transfer and jump instruction groups,
  with an AXI4-Lite slave through which software issues instructions,
  reads the working registers and observes program counter and ports.
  Assumes one clock, an active high asynchronous reset, and port input
  data coming from pins, so it is synchronised before use.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ltje_cfg.svh"

// Behaviour
// - Register-literal load writes 8-bit literal into destination register.
// - Destinations 07/17 select port address, 12/13 write port data.
// - Plain load accepts codes 00-06, 11, 14-16; literal 0 to 377.
// - Port data write drives literal; bank data register stays unchanged.
// - Port data write: code 12 left bank, code 13 right bank.
// - Bit field sends low L literal bits; beyond five, zeros fill.
// - Bit field bank value 2 is left, 3 is right, others accepted but drive no port.
// - Literal shifted so its LSB lands at bit position 0 to 7.
// - Length 1-7 literal width; length 0 means full eight bits.
// - Bit field write is read, shift, merge under mask, output.
// - Port bits outside position and length field are preserved.
// - Bit field literal comes from a five-bit instruction field.
// - Address select enables port at literal and stores literal.
// - Code 07 left bank register 7; code 17 right register 17.
// - Jump loads 13-bit field into program counter and address register.
// - Jump target spans program addresses 0 through 8191.
module ltje_exec
  import ltje_pkg::*;
(
  input  wire  logic        clk_sys,
  input  wire  logic        sys_rst,
  input  wire  logic [7:0]  left_port_in,
  input  wire  logic [7:0]  right_port_in,
  output var   logic [7:0]  left_port_out_q,
  output var   logic [7:0]  right_port_out_q,
  output var   logic        left_port_oe_q,
  output var   logic        right_port_oe_q,
  output var   logic [7:0]  left_sel_addr_q,
  output var   logic [7:0]  right_sel_addr_q,
  output var   logic        left_sel_q,
  output var   logic        right_sel_q,
  output var   logic [12:0] pc_q,
  output var   logic [12:0] prog_addr_q,
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output var   logic        s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output var   logic        s_axi_wready,
  output var   logic [1:0]  s_axi_bresp,
  output var   logic        s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output var   logic        s_axi_arready,
  output var   logic [31:0] s_axi_rdata,
  output var   logic [1:0]  s_axi_rresp,
  output var   logic        s_axi_rvalid,
  input  wire  logic        s_axi_rready
);

  // ****************************************************************
  // Field decoding.
  // ****************************************************************
  function automatic logic is_plain_dest(input logic [4:0] d);
    case (d)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
      5'h09, 5'h0C, 5'h0D, 5'h0E: is_plain_dest = 1'b1;
      default: is_plain_dest = 1'b0;
    endcase
  endfunction : is_plain_dest

  function automatic logic [3:0] reg_index(input logic [4:0] d);
    reg_index = {d[3], d[2:0]};
  endfunction : reg_index

  // ****************************************************************
  // Port input synchronisers.
  // ****************************************************************
  logic [7:0] lin_meta_q;
  logic [7:0] lin_q;
  logic [7:0] rin_meta_q;
  logic [7:0] rin_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lin_meta_q <= `LTJE_RST_BYTE;
      lin_q      <= `LTJE_RST_BYTE;
      rin_meta_q <= `LTJE_RST_BYTE;
      rin_q      <= `LTJE_RST_BYTE;
    end else begin
      lin_meta_q <= left_port_in;
      lin_q      <= lin_meta_q;
      rin_meta_q <= right_port_in;
      rin_q      <= rin_meta_q;
    end
  end

  // ****************************************************************
  // AXI4-Lite write path.
  // ****************************************************************
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        ctrl_halt_q;
  logic [15:0] instr_q;
  logic        issue_q;
  logic        refused_q;
  logic        wr_go;

  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // A new instruction is refused while a bit-field merge is still open.
  ltje_state_t state_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctrl_halt_q  <= 1'b0;
      instr_q      <= 16'h0000;
      issue_q      <= 1'b0;
    end else begin
      issue_q <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        case (awaddr_q)
          `LTJE_ADDR_CTRL: begin
            if (wstrb_q[0]) begin
              ctrl_halt_q <= wdata_q[0];
            end
          end
          `LTJE_ADDR_INSTR: begin
            if (ctrl_halt_q || state_q != LTJE_IDLE) begin
              s_axi_bresp <= 2'h2;
            end else begin
              instr_q <= wdata_q[15:0];
              issue_q <= 1'b1;
            end
          end
          `LTJE_ADDR_STATUS, `LTJE_ADDR_LPORT, `LTJE_ADDR_RPORT,
          `LTJE_ADDR_REGRD: begin
            s_axi_bresp <= 2'h0;
          end
          default: begin
            s_axi_bresp <= 2'h2;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Instruction execution.
  // ****************************************************************
  logic [2:0] opcode;
  logic [4:0] dst;
  logic [1:0] bank;
  logic [7:0] merged;
  logic       rf_we;
  logic [3:0] rf_waddr;
  logic [3:0] rf_raddr_q;
  logic [7:0] rf_rdata;
  logic [7:0] latch_q;
  logic       merge_right_q;

  assign opcode = instr_q[`LTJE_OP_MSB:`LTJE_OP_LSB];
  assign dst    = instr_q[`LTJE_DST_MSB:`LTJE_DST_LSB];
  assign bank   = instr_q[`LTJE_BANK_MSB:`LTJE_BANK_LSB];

  ltje_merge u_merge (
    .latched (latch_q),
    .literal (instr_q[4:0]),
    .pos     (instr_q[`LTJE_BFPOS_MSB:`LTJE_BFPOS_LSB]),
    .len     (instr_q[`LTJE_LEN_MSB:`LTJE_LEN_LSB]),
    .merged  (merged)
  );

  always_comb begin
    rf_we    = 1'b0;
    rf_waddr = reg_index(dst);
    if (state_q == LTJE_EXEC && opcode == `LTJE_OP_LITERAL) begin
      if (is_plain_dest(dst)) begin
        rf_we = 1'b1;
      end else if (dst == `LTJE_D_LEFT_ADDR
                   || dst == `LTJE_D_RIGHT_ADDR) begin
        rf_we = 1'b1;
      end
    end
  end

  ltje_regfile u_regs (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .we      (rf_we),
    .waddr   (rf_waddr),
    .wdata   (instr_q[7:0]),
    .raddr   (rf_raddr_q),
    .rdata_q (rf_rdata)
  );

  logic bitfield;
  assign bitfield = opcode == `LTJE_OP_LITERAL && !is_plain_dest(dst)
                    && dst != `LTJE_D_LEFT_ADDR && dst != `LTJE_D_RIGHT_ADDR
                    && dst != `LTJE_D_LEFT_DATA && dst != `LTJE_D_RIGHT_DATA;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q          <= LTJE_IDLE;
      pc_q             <= `LTJE_RST_PC;
      prog_addr_q      <= `LTJE_RST_PC;
      left_port_out_q  <= `LTJE_RST_BYTE;
      right_port_out_q <= `LTJE_RST_BYTE;
      left_port_oe_q   <= 1'b0;
      right_port_oe_q  <= 1'b0;
      left_sel_addr_q  <= `LTJE_RST_BYTE;
      right_sel_addr_q <= `LTJE_RST_BYTE;
      left_sel_q       <= 1'b0;
      right_sel_q      <= 1'b0;
      latch_q          <= `LTJE_RST_BYTE;
      merge_right_q    <= 1'b0;
    end else begin
      left_port_oe_q  <= 1'b0;
      right_port_oe_q <= 1'b0;
      case (state_q)
        LTJE_IDLE: begin
          if (issue_q) begin
            state_q <= LTJE_EXEC;
          end
        end
        LTJE_EXEC: begin
          state_q <= LTJE_IDLE;
          if (opcode == `LTJE_OP_JUMP) begin
            pc_q        <= instr_q[12:0];
            prog_addr_q <= instr_q[12:0];
          end else if (opcode == `LTJE_OP_LITERAL) begin
            pc_q        <= pc_q + 13'h0001;
            prog_addr_q <= pc_q + 13'h0001;
            if (dst == `LTJE_D_LEFT_DATA) begin
              left_port_out_q <= instr_q[7:0];
              left_port_oe_q  <= 1'b1;
            end else if (dst == `LTJE_D_RIGHT_DATA) begin
              right_port_out_q <= instr_q[7:0];
              right_port_oe_q  <= 1'b1;
            end else if (dst == `LTJE_D_LEFT_ADDR) begin
              left_sel_addr_q <= instr_q[7:0];
              left_sel_q      <= 1'b1;
              right_sel_q     <= 1'b0;
            end else if (dst == `LTJE_D_RIGHT_ADDR) begin
              right_sel_addr_q <= instr_q[7:0];
              right_sel_q      <= 1'b1;
              left_sel_q       <= 1'b0;
            end else if (bitfield && (bank == `LTJE_BANK_LEFT
                         || bank == `LTJE_BANK_RIGHT)) begin
              merge_right_q <= bank == `LTJE_BANK_RIGHT;
              latch_q <= (bank == `LTJE_BANK_RIGHT) ? rin_q : lin_q;
              state_q <= LTJE_MERGE;
            end
          end
        end
        LTJE_MERGE: begin
          state_q <= LTJE_IDLE;
          if (merge_right_q) begin
            right_port_out_q <= merged;
            right_port_oe_q  <= 1'b1;
          end else begin
            left_port_out_q <= merged;
            left_port_oe_q  <= 1'b1;
          end
        end
        default: begin
          state_q <= LTJE_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // AXI4-Lite read path.
  // ****************************************************************
  // Register reads take no extra cycle; the registered file output already follows rf_raddr_q.
  logic       rd_wait_q;
  logic [7:0] rd_addr_q;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
      rd_wait_q     <= 1'b0;
      rd_addr_q     <= 8'h00;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && !s_axi_arready && !rd_wait_q
          && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        rd_wait_q     <= 1'b1;
        rd_addr_q     <= s_axi_araddr;
      end else if (rd_wait_q && !s_axi_arready) begin
        rd_wait_q    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (rd_addr_q)
          `LTJE_ADDR_CTRL:   s_axi_rdata <= {31'h0, ctrl_halt_q};
          `LTJE_ADDR_INSTR:  s_axi_rdata <= {16'h0000, instr_q};
          `LTJE_ADDR_STATUS: s_axi_rdata <= {16'h0000, state_q == LTJE_IDLE,
                                             2'h0, pc_q};
          `LTJE_ADDR_LPORT:  s_axi_rdata <= {16'h0000, lin_q,
                                             left_port_out_q};
          `LTJE_ADDR_RPORT:  s_axi_rdata <= {16'h0000, rin_q,
                                             right_port_out_q};
          `LTJE_ADDR_REGRD:  s_axi_rdata <= {20'h00000, rf_raddr_q,
                                             rf_rdata};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end
  end

  // Register read index is written through the read-back register.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rf_raddr_q <= 4'h0;
    end else if (wr_go && awaddr_q == `LTJE_ADDR_REGRD && wstrb_q[1]) begin
      rf_raddr_q <= wdata_q[11:8];
    end
  end

endmodule : ltje_exec
`default_nettype wire

/* File: verification/ltje_port_model.sv */
/*
  Far-side byte ports of one bank, 256 addresses.
  Assumes select, address and output pulse come from the block.
*/
`timescale 1ns/1ps
`default_nettype none
module ltje_port_model (
  input  wire logic       clk_sys,
  input  wire logic       sel,
  input  wire logic [7:0] sel_addr,
  input  wire logic       oe,
  input  wire logic [7:0] out,
  output var  logic [7:0] port_in
);
  logic [7:0] mem [256];
  initial begin
    port_in = 8'h00;
    foreach (mem[i]) mem[i] = 8'hA5;
  end
  // A deselected bank toggles its lines, so stale data never reads as real.
  always @(posedge clk_sys) begin
    if (sel && oe) mem[sel_addr] <= out;
    port_in <= sel ? mem[sel_addr] : ~port_in;
  end
endmodule : ltje_port_model
`default_nettype wire

/* File: verification/ltje_exec_props.sv */
/*
  Checker for the execution block: ties accepted instruction writes to
  ports, selects and program counter. Assumes bready is high while waiting.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ltje_cfg.svh"
module ltje_props (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [7:0]  left_port_out_q,
  input wire logic [7:0]  right_port_out_q,
  input wire logic        left_port_oe_q,
  input wire logic        right_port_oe_q,
  input wire logic [7:0]  left_sel_addr_q,
  input wire logic [7:0]  right_sel_addr_q,
  input wire logic        left_sel_q,
  input wire logic        right_sel_q,
  input wire logic [12:0] pc_q,
  input wire logic [12:0] prog_addr_q,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  logic [7:0]  wa_q;
  logic [15:0] wd_q;
  logic        ok;
  logic        quiet;
  always_ff @(posedge clk_sys)
    if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
  always_ff @(posedge clk_sys)
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[15:0];
  assign ok = s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 &&
              wa_q == `LTJE_ADDR_INSTR;
  assign quiet = !left_port_oe_q && !right_port_oe_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence lit_to(logic [4:0] d);
    ok && wd_q[15:13] == `LTJE_OP_LITERAL && wd_q[12:8] == d;
  endsequence
  jump_load_a: assert property (ok && wd_q[15:13] == `LTJE_OP_JUMP
    |-> ##[0:6] pc_q == wd_q[12:0] && prog_addr_q == wd_q[12:0])
    else $error("jump target not loaded");
  left_data_a: assert property (lit_to(`LTJE_D_LEFT_DATA)
    |-> ##[0:6] left_port_oe_q && left_port_out_q == wd_q[7:0])
    else $error("left port data not driven");
  right_data_a: assert property (lit_to(`LTJE_D_RIGHT_DATA)
    |-> ##[0:6] right_port_oe_q && right_port_out_q == wd_q[7:0])
    else $error("right port data not driven");
  left_select_a: assert property (lit_to(`LTJE_D_LEFT_ADDR)
    |-> ##[0:6] left_sel_q && left_sel_addr_q == wd_q[7:0])
    else $error("left address not selected");
  right_select_a: assert property (lit_to(`LTJE_D_RIGHT_ADDR)
    |-> ##[0:6] right_sel_q && right_sel_addr_q == wd_q[7:0])
    else $error("right address not selected");
  oe_pulse_a: assert property (!quiet |=> quiet)
    else $error("output phase longer than one cycle");
  plain_quiet_a: assert property (ok && wd_q[15:13] == `LTJE_OP_LITERAL
    && wd_q[12:8] inside {[5'h00:5'h06], 5'h09, [5'h0C:5'h0E]} |-> quiet[*7])
    else $error("plain load touched a port");
  bad_bank_a: assert property (lit_to(5'h08) |-> quiet[*7])
    else $error("invalid bank drove a port");
  left_field_a: assert property (ok && wd_q[15:13] == `LTJE_OP_LITERAL
    && wd_q[12:11] == `LTJE_BANK_LEFT |-> ##[1:7] left_port_oe_q)
    else $error("left field write not output");
  right_field_a: assert property (ok && wd_q[15:13] == `LTJE_OP_LITERAL
    && wd_q[12:11] == `LTJE_BANK_RIGHT |-> ##[1:7] right_port_oe_q)
    else $error("right field write not output");
endmodule : ltje_props
bind ltje_exec ltje_props u_props (.*);
`default_nettype wire

/* File: verification/testbench.sv */
/*
  Self-checking bench: instructions enter over AXI4-Lite; ports, selects,
  registers and program counter are judged. Assumes two bank port models.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ltje_cfg.svh"
module testbench;
  logic        clk_sys, sys_rst, left_port_oe_q, right_port_oe_q;
  logic        left_sel_q, right_sel_q, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  left_port_in, right_port_in, left_port_out_q, right_port_out_q;
  logic [7:0]  left_sel_addr_q, right_sel_addr_q, s_axi_awaddr, s_axi_araddr;
  logic [12:0] pc_q, prog_addr_q;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          n_mismatch, n_compared, n_oe;
  ltje_exec DUT (.*);
  ltje_port_model u_left (.clk_sys(clk_sys), .sel(left_sel_q),
    .sel_addr(left_sel_addr_q), .oe(left_port_oe_q),
    .out(left_port_out_q), .port_in(left_port_in));
  ltje_port_model u_right (.clk_sys(clk_sys), .sel(right_sel_q),
    .sel_addr(right_sel_addr_q), .oe(right_port_oe_q),
    .out(right_port_out_q), .port_in(right_port_in));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) n_oe <= n_oe + left_port_oe_q + right_port_oe_q;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      n_mismatch++;
    end
  endtask : chk
  task automatic finish_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic [1:0] h;
    h = 2'h0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (!h[0] && s_axi_awready) begin
        h[0] = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!h[1] && s_axi_wready) begin
        h[1] = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (h != 2'h3);
    while (!s_axi_bvalid) @(posedge clk_sys);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk_sys);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // Waits after the response cover the issue, execute and merge stages.
  task automatic instr(input logic [15:0] w, input int noe);
    logic [1:0] r;
    int         b;
    b = n_oe;
    wr(`LTJE_ADDR_INSTR, {16'h0000, w}, r);
    chk(r, 2'h0);
    repeat (6) @(posedge clk_sys);
    chk(n_oe - b, noe);
  endtask : instr
  task automatic rdreg(input logic [3:0] i, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    wr(`LTJE_ADDR_REGRD, {20'h00000, i, 8'h00}, r);
    rd(`LTJE_ADDR_REGRD, d, r);
    chk(d[11:0], {i, e});
  endtask : rdreg
  task automatic bf(input logic [1:0] bk, input logic [2:0] p,
                    input logic [2:0] l, input logic [4:0] j,
                    inout logic [7:0] base);
    logic [15:0] m;
    logic [15:0] v;
    m = (16'h0001 << (l == 3'h0 ? 8 : l)) - 16'h0001;
    v = ({11'h000, j} & m) << p;
    m = m << p;
    base = (base & ~m[7:0]) | v[7:0];
    instr({`LTJE_OP_LITERAL, bk, p, l, j}, 1);
    chk(bk == 2'h3 ? right_port_out_q : left_port_out_q, base);
  endtask : bf
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk_sys);
    chk({pc_q, left_port_out_q, right_port_out_q, left_sel_q}, 0);
    rd(8'h40, d, r);
    chk(r, 2'h2);
    wr(8'h44, 32'h00000000, r);
    chk(r, 2'h2);
    wr(`LTJE_ADDR_CTRL, 32'h00000001, r);
    rd(`LTJE_ADDR_CTRL, d, r);
    chk(d, 32'h00000001);
    wr(`LTJE_ADDR_INSTR, {16'h0000, `LTJE_OP_JUMP, 13'h0123}, r);
    chk(r, 2'h2);
    wr(`LTJE_ADDR_CTRL, 32'h00000000, r);
    chk(pc_q, 13'h0000);
  endtask : t_reset
  task automatic t_load();
    logic [4:0] c [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                           5'h06, 5'h09, 5'h0C, 5'h0D, 5'h0E};
    foreach (c[k]) begin
      instr({`LTJE_OP_LITERAL, c[k], 8'hFF - 8'(k * 17)}, 0);
      rdreg(c[k][3:0], 8'hFF - 8'(k * 17));
    end
  endtask : t_load
  task automatic t_left();
    logic [7:0]  b;
    logic [31:0] d;
    logic [1:0]  r;
    instr({`LTJE_OP_LITERAL, `LTJE_D_LEFT_ADDR, 8'h5A}, 0);
    chk({left_sel_q, left_sel_addr_q}, 9'h15A);
    rdreg(4'h7, 8'h5A);
    instr({`LTJE_OP_LITERAL, `LTJE_D_LEFT_DATA, 8'hC3}, 1);
    chk(left_port_out_q, 8'hC3);
    rdreg(4'hA, 8'h00);
    b = 8'hC3;
    bf(2'h2, 3'h0, 3'h0, 5'h1F, b);
    bf(2'h2, 3'h7, 3'h3, 5'h05, b);
    bf(2'h2, 3'h3, 3'h5, 5'h0A, b);
    bf(2'h2, 3'h2, 3'h7, 5'h0E, b);
    rd(`LTJE_ADDR_LPORT, d, r);
    chk(d, {16'h0000, b, b});
  endtask : t_left
  task automatic t_right();
    logic [7:0]  b;
    logic [12:0] p;
    instr({`LTJE_OP_LITERAL, `LTJE_D_RIGHT_ADDR, 8'hA7}, 0);
    chk({right_sel_q, right_sel_addr_q}, 9'h1A7);
    rdreg(4'hF, 8'hA7);
    instr({`LTJE_OP_LITERAL, `LTJE_D_RIGHT_DATA, 8'h3C}, 1);
    chk(right_port_out_q, 8'h3C);
    rdreg(4'hB, 8'h00);
    b = 8'h3C;
    bf(2'h3, 3'h1, 3'h5, 5'h13, b);
    p = pc_q;
    instr({`LTJE_OP_LITERAL, 5'h08, 8'hFF}, 0);
    chk(pc_q, 13'(p + 13'h0001));
  endtask : t_right
  task automatic t_jump();
    logic [12:0] t [3] = '{13'h0000, 13'h1FFF, 13'h0171};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (t[k]) begin
      instr({`LTJE_OP_JUMP, t[k]}, 0);
      chk({pc_q, prog_addr_q}, {t[k], t[k]});
      rd(`LTJE_ADDR_STATUS, d, r);
      chk(d, {16'h0000, 1'b1, 2'h0, t[k]});
      instr({`LTJE_OP_LITERAL, 5'h00, 8'h11}, 0);
      chk(pc_q, 13'(t[k] + 13'h0001));
    end
  endtask : t_jump
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end
  initial begin
    sys_rst = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_load();
    t_left();
    t_right();
    t_jump();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
